/* File: core/ebi_share_arbiter.sv */
/*
 * Shared external bus arbiter with boot configuration control.
 * Port 0 is the test controller, ports 1..3 are memory controllers.
 * Assumes requesters are synchronous to clk_in and software uses
 * the plain register port with read data one cycle after the strobe.
 */
`timescale 1ns/1ps
`include "ebi_share_regs.svh"

module ebi_share_arbiter #(
	parameter logic [1:0] BOOT_WIDTH_DEFAULT = `EBI_WIDTH_8,
	parameter int PORTS = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire ebi_share_pkg::sw_cmd_t sw_cmd_in,
	output logic [31:0] sw_rdata_out,
	input wire logic [PORTS-1:0] shared_bus_request_in,
	output logic [PORTS-1:0] shared_bus_grant_out,
	output logic [PORTS-1:1] shared_bus_backoff_out,
	output logic shared_bus_enable_tie_out,
	output logic [1:0] boot_bank_width_strap_out,
	input wire logic [7:0] sys_addr_hi_in,
	input wire logic sys_sel_in,
	output logic [7:0] bank_chip_select_out,
	input wire logic reg_sel_in,
	input wire logic mem_access_active_in,
	output logic reg_sel_out,
	input wire logic clock_pad_in,
	output logic clock_pad_oe_out,
	output logic [3:0] feedback_clock_out
);

	// ***********************************
	// Helpers
	// ***********************************
	function automatic ebi_share_pkg::holder_t pick_highest(input logic [PORTS-1:0] req);
		ebi_share_pkg::holder_t h;
		h = '0;
		for (int i = PORTS - 1; i >= 0; i--) begin
			if (req[i]) begin
				h.valid = 1'b1;
				h.id = i[1:0];
			end
		end
		return h;
	endfunction : pick_highest

	ebi_share_pkg::arb_state_t state_q;
	ebi_share_pkg::holder_t holder_q;
	ebi_share_pkg::holder_t pick;
	logic enable_q;
	logic remap_q;
	logic [1:0] width_q;
	logic [31:0] grants_q;
	logic [PORTS-1:0] higher_req;
	logic [PORTS-1:0] others_req;

	// ***********************************
	// Register port
	// ***********************************
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			enable_q <= `EBI_CTRL_ENABLE_RST;
			remap_q <= `EBI_CTRL_REMAP_RST;
			width_q <= BOOT_WIDTH_DEFAULT;
		end else if (sw_cmd_in.wr && sw_cmd_in.addr == `EBI_REG_CTRL) begin
			enable_q <= sw_cmd_in.wdata[`EBI_CTRL_ENABLE_BIT];
			remap_q <= sw_cmd_in.wdata[`EBI_CTRL_REMAP_BIT];
			width_q <= sw_cmd_in.wdata[`EBI_CTRL_WIDTH_LSB +: 2];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sw_rdata_out <= 32'h0000_0000;
		end else if (sw_cmd_in.rd) begin
			unique case (sw_cmd_in.addr)
				`EBI_REG_CTRL: sw_rdata_out <= {28'h000_0000, width_q, remap_q, enable_q};
				`EBI_REG_STATUS: sw_rdata_out <= {27'h000_0000, mem_access_active_in,
					(state_q == ebi_share_pkg::ARB_BACKOFF), holder_q.id, holder_q.valid};
				`EBI_REG_GRANTS: sw_rdata_out <= grants_q;
				default: sw_rdata_out <= 32'h0000_0000;
			endcase
		end else begin
			sw_rdata_out <= 32'h0000_0000;
		end
	end

	// ***********************************
	// Pins toward the device
	// ***********************************
	// Sharing always on: the device only uses its request pins then
	assign shared_bus_enable_tie_out = 1'b1;
	// Strap is a steady level; device samples it during its own reset
	assign boot_bank_width_strap_out = width_q;
	// Separate buses: hold off register selects during memory traffic
	assign reg_sel_out = reg_sel_in && !mem_access_active_in;
	// Pad limited wiring: pad output enable held low, pad input fans out
	assign clock_pad_oe_out = 1'b0;
	assign feedback_clock_out = {4{clock_pad_in}};

	boot_decoder u_boot_decoder (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.addr_hi_in(sys_addr_hi_in),
		.sel_in(sys_sel_in),
		.remap_in(remap_q),
		.bank_chip_select_out(bank_chip_select_out)
	);

	// ***********************************
	// Arbitration
	// ***********************************
	// Lower index wins, so port 0 (test) outranks controller 1
	always_comb begin
		others_req = shared_bus_request_in;
		if (holder_q.valid) begin
			others_req[holder_q.id] = 1'b0;
		end
		pick = pick_highest(enable_q ? others_req : '0);
		higher_req = '0;
		for (int i = 0; i < PORTS; i++) begin
			higher_req[i] = holder_q.valid && (i < int'(holder_q.id)) && shared_bus_request_in[i];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= ebi_share_pkg::ARB_IDLE;
			holder_q <= '0;
		end else begin
			unique case (state_q)
				ebi_share_pkg::ARB_IDLE: begin
					if (pick.valid) begin
						state_q <= ebi_share_pkg::ARB_HELD;
						holder_q <= pick;
					end
				end
				ebi_share_pkg::ARB_HELD, ebi_share_pkg::ARB_BACKOFF: begin
					if (!shared_bus_request_in[holder_q.id]) begin
						// Released: hand over at once; releaser must wait a cycle anyway
						state_q <= pick.valid ? ebi_share_pkg::ARB_HELD : ebi_share_pkg::ARB_IDLE;
						holder_q <= pick;
					end else if (|higher_req && holder_q.id != 2'h0) begin
						state_q <= ebi_share_pkg::ARB_BACKOFF;
					end
				end
				// Unused code: fall back to a free bus
				default: begin
					state_q <= ebi_share_pkg::ARB_IDLE;
					holder_q <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			grants_q <= 32'h0000_0000;
		end else if (pick.valid && (state_q == ebi_share_pkg::ARB_IDLE || !shared_bus_request_in[holder_q.id])) begin
			grants_q <= grants_q + 32'h0000_0001;
		end
	end

	always_comb begin
		shared_bus_grant_out = '0;
		shared_bus_backoff_out = '0;
		if (holder_q.valid) begin
			shared_bus_grant_out[holder_q.id] = 1'b1;
			if (state_q == ebi_share_pkg::ARB_BACKOFF && holder_q.id != 2'h0) begin
				shared_bus_backoff_out[holder_q.id] = 1'b1;
			end
		end
	end

	// ***********************************
	// Checks
	// ***********************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_bus_free_req;
		state_q == ebi_share_pkg::ARB_IDLE && enable_q && |shared_bus_request_in;
	endsequence
	sequence s_higher_arrives;
		holder_q.valid && holder_q.id != 2'h0 && shared_bus_request_in[holder_q.id] && |higher_req;
	endsequence

	a_grant_onehot: assert property ($onehot0(shared_bus_grant_out))
		else $error("more than one grant");
	a_grant_at_once: assert property (s_bus_free_req |=> |shared_bus_grant_out)
		else $error("free bus request not granted next cycle");
	a_priority_pick: assert property (s_bus_free_req |=>
		shared_bus_grant_out == ($past(shared_bus_request_in) & -$past(shared_bus_request_in)))
		else $error("grant not to highest priority requester");
	a_hold_until_drop: assert property ((shared_bus_grant_out & shared_bus_request_in) != '0
		|=> shared_bus_grant_out == $past(shared_bus_grant_out))
		else $error("grant moved while holder still requests");
	a_backoff_raised: assert property (s_higher_arrives |=>
		shared_bus_backoff_out[$past(holder_q.id)] ##0 shared_bus_grant_out == $past(shared_bus_grant_out))
		else $error("higher request did not raise backoff");
	a_backoff_only_holder: assert property ((shared_bus_backoff_out & ~shared_bus_grant_out[PORTS-1:1]) == '0)
		else $error("backoff to a port not holding the bus");
	a_test_keeps_bus: assert property (shared_bus_grant_out[0] && shared_bus_request_in[0]
		|=> shared_bus_grant_out[0] && shared_bus_backoff_out == '0)
		else $error("test controller forced off");
	a_release_handover: assert property (holder_q.valid && !shared_bus_request_in[holder_q.id]
		|=> shared_bus_grant_out[$past(holder_q.id)] == 1'b0)
		else $error("released holder kept the grant");
	a_reg_gate: assert property (mem_access_active_in |-> !reg_sel_out)
		else $error("register select during memory access");
	a_strap_follows: assert property ($changed(width_q) |-> ##[0:1] boot_bank_width_strap_out == width_q)
		else $error("strap output not following control");
	a_pad_single: assert property (clock_pad_oe_out == 1'b0 ##0 feedback_clock_out == {4{clock_pad_in}})
		else $error("single clock pad wiring wrong");
	a_idle_no_grant: assert property (!enable_q && state_q == ebi_share_pkg::ARB_IDLE
		|=> shared_bus_grant_out == '0)
		else $error("grant while arbiter disabled");
	a_unmapped_read: assert property (sw_cmd_in.rd && sw_cmd_in.addr != `EBI_REG_CTRL
		&& sw_cmd_in.addr != `EBI_REG_STATUS && sw_cmd_in.addr != `EBI_REG_GRANTS
		|=> sw_rdata_out == 32'h0000_0000)
		else $error("unmapped read returned data");
	a_rdata_one_cycle: assert property (!$past(sw_cmd_in.rd) |-> sw_rdata_out == 32'h0000_0000)
		else $error("read data outside its cycle");
	a_ctrl_write: assert property (sw_cmd_in.wr && sw_cmd_in.addr == `EBI_REG_CTRL |=>
		remap_q == $past(sw_cmd_in.wdata[`EBI_CTRL_REMAP_BIT])
		&& boot_bank_width_strap_out == $past(sw_cmd_in.wdata[`EBI_CTRL_WIDTH_LSB +: 2]))
		else $error("control write not taken");
	a_grant_count: assert property (s_bus_free_req |=> grants_q == $past(grants_q) + 32'h0000_0001)
		else $error("grant counter missed a grant");
	a_backoff_stands: assert property ((shared_bus_backoff_out & shared_bus_request_in[PORTS-1:1]) != '0
		|=> shared_bus_backoff_out == $past(shared_bus_backoff_out))
		else $error("backoff dropped before release");
	a_backoff_status: assert property (sw_cmd_in.rd && sw_cmd_in.addr == `EBI_REG_STATUS |=>
		sw_rdata_out[`EBI_STAT_BACKOFF_BIT] == |$past(shared_bus_backoff_out))
		else $error("status backoff bit wrong");
	a_no_spurious_backoff: assert property (state_q == ebi_share_pkg::ARB_HELD && !(|higher_req)
		|=> shared_bus_backoff_out == '0)
		else $error("backoff without a higher request");
	a_reg_pass: assert property (reg_sel_in && !mem_access_active_in |-> reg_sel_out)
		else $error("register select blocked while bus free");
	a_tie_high: assert property (shared_bus_enable_tie_out)
		else $error("sharing tie not high");

endmodule : ebi_share_arbiter

/* File: core/ebi_share_regs.svh */
/*
 * Offsets, field positions, reset values and region codes for the
 * shared-bus arbiter and its boot decoder.
 * Assumes inclusion by bare name from the arbiter, decoder and bench modules.
 */
`ifndef EBI_SHARE_REGS_SVH
`define EBI_SHARE_REGS_SVH

// ***********************************
// Register offsets
// ***********************************
`define EBI_REG_CTRL 8'h00
`define EBI_REG_STATUS 8'h04
`define EBI_REG_GRANTS 8'h08

// ***********************************
// Control fields
// ***********************************
`define EBI_CTRL_ENABLE_BIT 0
`define EBI_CTRL_REMAP_BIT 1
`define EBI_CTRL_WIDTH_LSB 2
`define EBI_CTRL_ENABLE_RST 1'b1
`define EBI_CTRL_REMAP_RST 1'b0

// ***********************************
// Status fields
// ***********************************
`define EBI_STAT_VALID_BIT 0
`define EBI_STAT_HOLDER_LSB 1
`define EBI_STAT_BACKOFF_BIT 3
`define EBI_STAT_MEMBUSY_BIT 4

// ***********************************
// Boot strap width codes
// ***********************************
`define EBI_WIDTH_8 2'h0
`define EBI_WIDTH_16 2'h1
`define EBI_WIDTH_32 2'h2
`define EBI_WIDTH_KEEP 2'h3

// ***********************************
// Address regions, top byte
// ***********************************
`define EBI_REGION_LOW 8'h00
`define EBI_REGION_ROM 8'h0F
`define EBI_REGION_BANKS 4'h1
`define EBI_BOOT_BANK 3'h7
`define EBI_RAM_BANK 3'h0

`endif

/* File: core/ebi_share_pkg.sv */
/*
 * Types shared by the shared-bus arbiter and its bench.
 * Assumes ebi_share_regs.svh is on the include path.
 */
package ebi_share_pkg;

	// ***********************************
	// Arbiter state
	// ***********************************
	typedef enum logic [1:0] {
		ARB_IDLE,
		ARB_HELD,
		ARB_BACKOFF
	} arb_state_t;

	// ***********************************
	// Software command port
	// ***********************************
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sw_cmd_t;

	// ***********************************
	// Arbiter grant picture
	// ***********************************
	typedef struct packed {
		logic valid;
		logic [1:0] id;
	} holder_t;

endpackage : ebi_share_pkg

/* File: core/boot_decoder.sv */
/*
 * System address decoder: boot ROM alias at zero until remap,
 * eight bank selects for the memory port.
 * Assumes the top address byte is stable with its select strobe.
 */
`timescale 1ns/1ps
`include "ebi_share_regs.svh"

module boot_decoder (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr_hi_in,
	input wire logic sel_in,
	input wire logic remap_in,
	output logic [7:0] bank_chip_select_out
);

	// ***********************************
	// Decode
	// ***********************************
	always_comb begin
		bank_chip_select_out = 8'h00;
		if (sel_in) begin
			if (addr_hi_in == `EBI_REGION_LOW) begin
				// Boot ROM on the boot bank until software sets remap
				bank_chip_select_out[remap_in ? `EBI_RAM_BANK : `EBI_BOOT_BANK] = 1'b1;
			end else if (addr_hi_in == `EBI_REGION_ROM) begin
				bank_chip_select_out[`EBI_BOOT_BANK] = 1'b1;
			end else if (addr_hi_in[7:4] == `EBI_REGION_BANKS && !addr_hi_in[3]) begin
				bank_chip_select_out[addr_hi_in[2:0]] = 1'b1;
			end
		end
	end

	// ***********************************
	// Checks
	// ***********************************
	a_boot_alias_rom: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sel_in && !remap_in && addr_hi_in == `EBI_REGION_LOW |-> bank_chip_select_out == 8'h80)
		else $error("boot alias does not select the boot bank");
	a_remap_ram: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		sel_in && remap_in && addr_hi_in == `EBI_REGION_LOW |-> bank_chip_select_out == 8'h01)
		else $error("remapped zero does not select RAM");
	a_select_onehot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$onehot0(bank_chip_select_out))
		else $error("bank selects not one-hot");
	a_select_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!sel_in |-> bank_chip_select_out == 8'h00)
		else $error("bank select without address valid");

endmodule : boot_decoder

/* File: testbench/mem_ctrl_model.sv */
/*
 * Behavioural memory controller on one port of the shared-bus arbiter.
 * Assumes grant and backoff come from clk_in logic; start_in is a one-cycle pulse.
 */
`timescale 1ns/1ps

module mem_ctrl_model #(
	parameter int LEN = 6
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic enable_tie_in,
	input wire logic [1:0] width_strap_in,
	input wire logic grant_in,
	input wire logic backoff_in,
	output logic req_out
);
	// ***********************************
	// Transfer engine
	// ***********************************
	logic pend_q;
	logic quiet_q;
	logic [3:0] left_q;
	logic [1:0] width_q;
	logic lane_en_q;
	logic sync_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			if (width_strap_in != 2'h3) begin
				width_q <= width_strap_in;
			end
			lane_en_q <= 1'b0;
			sync_q <= 1'b0;
			pend_q <= 1'b0;
			quiet_q <= 1'b0;
			left_q <= 4'h0;
		end else begin
			quiet_q <= 1'b0;
			if (start_in) begin
				pend_q <= 1'b1;
				left_q <= 4'(LEN);
			end else if (pend_q && grant_in && backoff_in && !quiet_q) begin
				// Remaining count kept so the cut transfer resumes
				quiet_q <= 1'b1;
			end else if (pend_q && grant_in && !quiet_q) begin
				left_q <= left_q - 4'h1;
				if (left_q == 4'h1) begin
					pend_q <= 1'b0;
				end
			end
		end
	end

	assign req_out = pend_q && !quiet_q && enable_tie_in;
endmodule : mem_ctrl_model

/* File: testbench/ext_bus_share_and_boot_cfg_bench.sv */
/*
 * Self-checking bench for the shared-bus arbiter and boot decoder.
 * Assumes three controller models on ports 1..3; bench drives port 0.
 */
`timescale 1ns/1ps
`include "ebi_share_regs.svh"

module ext_bus_share_and_boot_cfg_bench;
	logic clk_in = 1'b0;
	logic rst_n = 1'b0;
	ebi_share_pkg::sw_cmd_t cmd = '0;
	logic [31:0] rdata;
	logic [3:0] grant;
	logic [3:1] backoff;
	logic [3:0] start = 4'h0;
	logic req0 = 1'b0;
	logic reg_req = 1'b1;
	wire [3:0] req;
	logic tie, pad_oe, reg_sel, pad = 1'b0, sel_in = 1'b0, mem_act = 1'b0;
	logic [1:0] strap;
	logic [7:0] addr_hi = 8'h00;
	logic [7:0] cs;
	logic [3:0] fb;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;

	initial forever #25 clk_in = ~clk_in;
	assign req[0] = req0;

	ebi_share_arbiter u_dut (.clk_in(clk_in), .rst_n_in(rst_n), .sw_cmd_in(cmd), .sw_rdata_out(rdata),
		.shared_bus_request_in(req), .shared_bus_grant_out(grant), .shared_bus_backoff_out(backoff),
		.shared_bus_enable_tie_out(tie), .boot_bank_width_strap_out(strap), .sys_addr_hi_in(addr_hi),
		.sys_sel_in(sel_in), .bank_chip_select_out(cs), .reg_sel_in(reg_req), .mem_access_active_in(mem_act),
		.reg_sel_out(reg_sel), .clock_pad_in(pad), .clock_pad_oe_out(pad_oe), .feedback_clock_out(fb));

	for (genvar i = 1; i < 4; i++) begin : g_mc
		mem_ctrl_model u_mc (.clk_in(clk_in), .rst_n_in(rst_n), .start_in(start[i]), .enable_tie_in(tie),
			.width_strap_in(strap), .grant_in(grant[i]), .backoff_in(backoff[i]), .req_out(req[i]));
	end

	// ***********************************
	// Access tasks
	// ***********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cmd.addr <= a;
		cmd.wdata <= d;
		cmd.wr <= 1'b1;
		@(posedge clk_in);
		cmd.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		cmd.addr <= a;
		cmd.rd <= 1'b1;
		@(posedge clk_in);
		cmd.rd <= 1'b0;
		#1 check(rdata, exp);
	endtask : rd

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : step

	// Bounded so a lost grant ends in a mismatch, not a hang
	task automatic wait_grant(input int p);
		int n;
		n = 0;
		while (grant[p] !== 1'b1 && n < 60) begin
			step(1);
			n++;
		end
		check(32'(grant), 32'(1 << p));
	endtask : wait_grant

	task automatic dec(input logic [7:0] a, input logic [7:0] exp);
		addr_hi <= a;
		step(1);
		check(32'(cs), 32'(exp));
	endtask : dec

	task automatic pulse(input logic [3:0] m);
		start <= m;
		@(posedge clk_in);
		start <= 4'h0;
	endtask : pulse

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			give_verdict();
		end
	end

	// ***********************************
	// Tests
	// ***********************************
	initial begin
		repeat (4) @(posedge clk_in);
		rst_n <= 1'b1;
		@(posedge clk_in);
		rd(`EBI_REG_CTRL, 32'h0000_0001);
		rd(`EBI_REG_STATUS, 32'h0000_0000);
		rd(`EBI_REG_GRANTS, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		check(32'(tie), 32'h0000_0001);
		pad <= 1'b1;
		step(1);
		check(32'({pad_oe, fb}), 32'h0000_000F);
		pad <= 1'b0;
		step(1);
		check(32'({pad_oe, fb}), 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			wr(`EBI_REG_CTRL, 32'(k << 2) | 32'h1);
			#1 check(32'(strap), 32'(k));
			rd(`EBI_REG_CTRL, 32'(k << 2) | 32'h1);
		end
		sel_in <= 1'b1;
		dec(8'h00, 8'h80);
		dec(8'h0F, 8'h80);
		dec(8'h13, 8'h08);
		dec(8'h17, 8'h80);
		dec(8'h20, 8'h00);
		wr(`EBI_REG_CTRL, 32'h0000_0003);
		dec(8'h00, 8'h01);
		dec(8'h0F, 8'h80);
		mem_act <= 1'b1;
		step(1);
		check(32'(reg_sel), 32'h0000_0000);
		rd(`EBI_REG_STATUS, 32'h0000_0010);
		mem_act <= 1'b0;
		step(1);
		check(32'(reg_sel), 32'h0000_0001);
		reg_req <= 1'b0;
		step(1);
		check(32'(reg_sel), 32'h0000_0000);
		reg_req <= 1'b1;
		pulse(4'b0100);
		step(1);
		check(32'(grant), 32'h0000_0004);
		rd(`EBI_REG_STATUS, 32'h0000_0005);
		pulse(4'b0010);
		step(1);
		check(32'(backoff), 32'h0000_0002);
		rd(`EBI_REG_STATUS, 32'h0000_000D);
		wait_grant(1);
		wait_grant(2);
		step(8);
		pulse(4'b1010);
		wait_grant(1);
		wait_grant(3);
		step(8);
		req0 <= 1'b1;
		wait_grant(0);
		pulse(4'b1000);
		step(4);
		check(32'({backoff, grant}), 32'h0000_0001);
		req0 <= 1'b0;
		wait_grant(3);
		step(8);
		wr(`EBI_REG_CTRL, 32'h0000_0000);
		pulse(4'b0100);
		step(4);
		check(32'(grant), 32'h0000_0000);
		wr(`EBI_REG_CTRL, 32'h0000_0001);
		wait_grant(2);
		rd(`EBI_REG_GRANTS, 32'h0000_0008);
		step(8);
		// Mid-run reset must restore remap, strap and the counter
		wr(`EBI_REG_CTRL, 32'h0000_000B);
		#1 check(32'(strap), 32'h0000_0002);
		rst_n <= 1'b0;
		step(4);
		rst_n <= 1'b1;
		rd(`EBI_REG_CTRL, 32'h0000_0001);
		rd(`EBI_REG_GRANTS, 32'h0000_0000);
		check(32'({strap, cs}), 32'h0000_0080);
		check(32'(grant), 32'h0000_0000);
		give_verdict();
	end
endmodule : ext_bus_share_and_boot_cfg_bench
